// [test_timer_mode_polarity_control.sv]
// Purpose: self-checking bench for the timer mode and polarity control
// Assumes: one-cycle Wishbone ack, counter runs from 1 up to reload
// Notes: reload 3 toggles the output every 3 prescaled ticks, a period of 6

`timescale 1ns/10ps
`default_nettype none

module test_timer_mode_polarity_control;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic ack;
  logic wantLevel = 1'b0;
  logic timerIn;
  logic timerOut;
  logic irq;
  int errCount = 0;
  int totalChecks = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  timer_mode_polarity_control u_dut (.clk(clk), .arst_n(arst_n),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .timerIn(timerIn),
    .timerOut(timerOut), .irq(irq));

  timer_pin_model u_pin (.clk(clk), .arst_n(arst_n),
    .wantLevel(wantLevel), .pinLevel(timerIn));

  // ==========================================================
  // shared tasks
  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic [11:0] idx, input logic wr,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= {2'h0, idx, 2'h0};
    sel <= 4'hF;
    wdat <= wd;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
  endtask

  task automatic regWrite(input logic [11:0] idx, input logic [31:0] wd);
    logic [31:0] unused;
    bus(idx, 1'b1, wd, unused);
  endtask

  task automatic regRead(input logic [11:0] idx, output logic [31:0] rd);
    bus(idx, 1'b0, 32'h0000_0000, rd);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic pin(input logic v);
    @(posedge clk);
    wantLevel <= v;
    idle(3);
  endtask

  // stop first so the prescaler restarts from zero
  task automatic cfg(input logic pol, input logic [2:0] prescale_field,
                     input logic [3:0] mode, input logic [31:0] rel,
                     input logic [31:0] pw);
    regWrite(timer_ctl_pkg::IDX_CTRL, 32'h0000_0000);
    regWrite(timer_ctl_pkg::IDX_MODE_HI, {31'h0, mode[3]});
    regWrite(timer_ctl_pkg::IDX_RELOAD, rel);
    regWrite(timer_ctl_pkg::IDX_PWM, pw);
    regWrite(timer_ctl_pkg::IDX_STATUS, 32'h0000_0007);
    regWrite(timer_ctl_pkg::IDX_CTRL, {24'h0, 1'b1, pol, prescale_field, mode[2:0]});
  endtask

  // cycles until the output pin next changes
  task automatic gap(output int n);
    logic last;
    @(negedge clk);
    last = timerOut;
    n = 1;
    while (timerOut === last && n < 2000) begin
      @(negedge clk);
      n++;
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic testReset();
    logic [31:0] d;
    regRead(timer_ctl_pkg::IDX_CTRL, d);
    check(d, 32'h0000_0000);
    check({31'h0, timerOut}, 32'h0000_0000);
    regRead(12'h123, d);
    check(d, 32'h0000_0000);
    regWrite(timer_ctl_pkg::IDX_CTRL, 32'h0000_0040);
    idle(2);
    check({31'h0, timerOut}, 32'h0000_0001);
    regRead(timer_ctl_pkg::IDX_CTRL, d);
    check(d, 32'h0000_0040);
    $display("done reset and stopped output");
  endtask

  task automatic testToggle();
    logic [3:0] modes [5] = '{4'h1, 4'h4, 4'h5, 4'h6, 4'h9};
    int n;
    pin(1'b1);
    regWrite(timer_ctl_pkg::IDX_MASK, 32'h0000_0001);
    foreach (modes[i]) begin
      for (int p = 0; p < 3; p += 2) begin
        cfg(1'b0, 3'(p), modes[i], 32'h0000_0003, 32'h0000_0000);
        gap(n);
        gap(n);
        check(32'(n), 32'(3 << p));
        check({31'h0, irq}, 32'h0000_0001);
      end
    end
    regWrite(timer_ctl_pkg::IDX_MASK, 32'h0000_0000);
    $display("done toggle period");
  endtask

  task automatic testOneShot();
    logic [31:0] d;
    int n;
    cfg(1'b0, 3'h0, 4'h0, 32'h0000_0003, 32'h0000_0000);
    gap(n);
    check({31'h0, timerOut}, 32'h0000_0001);
    n = 0;
    while (timerOut === 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    check(32'(n), 32'h0000_0001);
    regRead(timer_ctl_pkg::IDX_CTRL, d);
    check({31'h0, d[7]}, 32'h0000_0000);
    $display("done single shot");
  endtask

  task automatic testCapture();
    logic [31:0] d;
    for (int p = 0; p < 2; p++) begin
      pin(!p[0]);
      cfg(p[0], 3'h0, 4'h4, 32'h0000_FFFF, 32'h0000_0000);
      regWrite(timer_ctl_pkg::IDX_MASK, 32'h0000_0002);
      pin(p[0]);
      regRead(timer_ctl_pkg::IDX_STATUS, d);
      check(d & 32'h2, 32'h0000_0000);
      check({31'h0, irq}, 32'h0000_0000);
      pin(!p[0]);
      regRead(timer_ctl_pkg::IDX_STATUS, d);
      check(d & 32'h2, 32'h0000_0002);
      check({31'h0, irq}, 32'h0000_0001);
      regWrite(timer_ctl_pkg::IDX_STATUS, 32'h0000_0002);
      idle(2);
      check({31'h0, irq}, 32'h0000_0000);
      regWrite(timer_ctl_pkg::IDX_MASK, 32'h0000_0000);
    end
    $display("done capture edges and interrupt");
  endtask

  task automatic testCounter();
    logic [31:0] a;
    logic [31:0] b;
    for (int p = 0; p < 2; p++) begin
      pin(p[0]);
      cfg(p[0], 3'h0, 4'h2, 32'h0000_FFFF, 32'h0000_0000);
      regRead(timer_ctl_pkg::IDX_COUNT, a);
      repeat (3) begin
        pin(!p[0]);
        pin(p[0]);
      end
      regRead(timer_ctl_pkg::IDX_COUNT, b);
      check(b - a, 32'h0000_0003);
    end
    $display("done event counter");
  endtask

  task automatic testGated();
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] d;
    pin(1'b0);
    cfg(1'b0, 3'h0, 4'h6, 32'h0000_FFFF, 32'h0000_0000);
    regRead(timer_ctl_pkg::IDX_COUNT, a);
    idle(10);
    regRead(timer_ctl_pkg::IDX_COUNT, b);
    check(b, a);
    pin(1'b1);
    idle(10);
    regRead(timer_ctl_pkg::IDX_STATUS, d);
    check(d & 32'h4, 32'h0000_0000);
    regRead(timer_ctl_pkg::IDX_COUNT, a);
    check({31'h0, a > b}, 32'h0000_0001);
    pin(1'b0);
    regRead(timer_ctl_pkg::IDX_STATUS, d);
    check(d & 32'h4, 32'h0000_0004);
    $display("done gated count");
  endtask

  task automatic testCapCmp();
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] c;
    logic [31:0] d;
    pin(1'b0);
    cfg(1'b0, 3'h0, 4'h7, 32'h0000_FFFF, 32'h0000_0000);
    regRead(timer_ctl_pkg::IDX_COUNT, a);
    idle(4);
    regRead(timer_ctl_pkg::IDX_COUNT, b);
    check(b, a);
    pin(1'b1);
    regRead(timer_ctl_pkg::IDX_STATUS, d);
    check(d & 32'h2, 32'h0000_0000);
    regRead(timer_ctl_pkg::IDX_COUNT, c);
    check({31'h0, c > b}, 32'h0000_0001);
    pin(1'b0);
    pin(1'b1);
    regRead(timer_ctl_pkg::IDX_STATUS, d);
    check(d & 32'h2, 32'h0000_0002);
    regRead(timer_ctl_pkg::IDX_CAPTURE, d);
    check({31'h0, d > c}, 32'h0000_0001);
    $display("done capture/compare start and capture");
  endtask

  // high for reload - pwm cycles, low for pwm - start + 1 cycles
  task automatic testPwm();
    int hi;
    int n;
    for (int m = 0; m < 2; m++) begin
      cfg(1'b0, 3'h0, (m == 1) ? 4'h8 : 4'h3, 32'h0000_0009,
          32'h0000_0004);
      gap(n);
      check({31'h0, timerOut}, 32'h0000_0001);
      gap(n);
      check(32'(n), 32'h0000_0005);
      gap(n);
      check(32'(n), 32'h0000_0004);
      hi = 0;
      repeat (40) begin
        @(negedge clk);
        if (timerOut === 1'b1) hi++;
      end
      check({31'h0, hi > 0 && hi < 40}, 32'h0000_0001);
      regWrite(timer_ctl_pkg::IDX_CTRL, 32'h0000_0000);
      idle(2);
      check({31'h0, timerOut}, 32'h0000_0000);
    end
    $display("done single and dual pwm");
  endtask

  // ==========================================================
  // hang guard and main sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errCount++;
      tallyAndFinish();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    testReset();
    testToggle();
    testOneShot();
    testPwm();
    testCapture();
    testCounter();
    testGated();
    testCapCmp();
    tallyAndFinish();
  end
endmodule

`default_nettype wire

// [timer_ctl_pkg.sv]
// Purpose: shared constants for the timer mode and polarity control block
// Assumes: 32-bit classic Wishbone, byte addresses = register index * 4
// Notes: register index values, field positions and mode codes live here

package timer_ctl_pkg;

  // ==========================================================
  // register indices and byte addresses
  localparam int ADDR_W = 16;
  localparam logic [11:0] IDX_CTRL = 12'hF07;
  localparam logic [11:0] IDX_MODE_HI = 12'hF20;
  localparam logic [11:0] IDX_RELOAD = 12'hF21;
  localparam logic [11:0] IDX_PWM = 12'hF22;
  localparam logic [11:0] IDX_COUNT = 12'hF23;
  localparam logic [11:0] IDX_CAPTURE = 12'hF24;
  localparam logic [11:0] IDX_STATUS = 12'hF25;
  localparam logic [11:0] IDX_MASK = 12'hF26;
  localparam logic [1:0] BYTE_OFS = 2'h0;

  // ==========================================================
  // control register layout
  localparam int RUN_BIT = 7;
  localparam int POL_BIT = 6;
  localparam int PRESCALE_FIELD_LSB = 3;
  localparam int PRESCALE_FIELD_W = 3;
  localparam int MODE_LSB = 0;
  localparam int MODE_LO_W = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ==========================================================
  // status and mask layout
  localparam int STATUS_W = 3;
  localparam int ST_RELOAD = 0;
  localparam int ST_CAPTURE = 1;
  localparam int ST_GATE = 2;
  localparam logic [STATUS_W-1:0] STATUS_RESET = 3'h0;
  localparam logic [STATUS_W-1:0] MASK_RESET = 3'h0;

  // ==========================================================
  // operating modes
  typedef enum logic [3:0] {
    MODE_ONESHOT = 4'h0,
    MODE_CONT = 4'h1,
    MODE_COUNTER = 4'h2,
    MODE_PWM_ONE = 4'h3,
    MODE_CAPTURE = 4'h4,
    MODE_COMPARE = 4'h5,
    MODE_GATED = 4'h6,
    MODE_CAP_CMP = 4'h7,
    MODE_PWM_TWO = 4'h8,
    MODE_CAP_RESTART = 4'h9,
    MODE_CMP_COUNTER = 4'hA,
    MODE_TRIG_ONESHOT = 4'hB
  } mode_t;

  function automatic logic [ADDR_W-1:0] byteAddr(input logic [11:0] idx);
    byteAddr = {2'h0, idx, BYTE_OFS};
  endfunction

endpackage

// [timer_input_edge.sv]
// Purpose: polarity-aware edge and level detection on the timer input
// Assumes: input pin already synchronous to clk
// Notes: active edge is rising for polarity 0, falling for polarity 1

`timescale 1ns/10ps
`default_nettype none

module timer_input_edge (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic pinIn,
  input wire logic polarity,
  output logic activeEdge,
  output logic otherEdge,
  output logic activeLevel
);

  typedef struct packed {
    logic prev;
    logic valid;
  } edge_state_t;

  edge_state_t q;
  edge_state_t d;
  logic rise;
  logic fall;

  // ==========================================================
  // edge selection
  always_comb begin
    d.prev = pinIn;
    d.valid = 1'b1;
    rise = q.valid && !q.prev && pinIn;
    fall = q.valid && q.prev && !pinIn;
    activeEdge = polarity ? fall : rise;
    otherEdge = polarity ? rise : fall;
    activeLevel = pinIn ^ polarity;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  a_edge_select: assert property (@(posedge clk) disable iff (!arst_n)
    activeEdge |-> (pinIn != $past(pinIn)) && (pinIn == !polarity))
    else $error("active edge not of selected polarity");

endmodule

`default_nettype wire

// [timer_mode_polarity_control.sv]
// Purpose: timer control register, mode decode and output/capture logic
// Assumes: classic Wishbone slave, one clock, inputs synchronous
// Notes: one-cycle ack latency, status bits write-one-to-clear

`timescale 1ns/10ps
`default_nettype none

module timer_mode_polarity_control #(
  parameter int CNT_W = 16,
  parameter logic [CNT_W-1:0] RELOAD_RESET = '1,
  parameter logic [CNT_W-1:0] COUNT_START = CNT_W'(1)
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [timer_ctl_pkg::ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic timerIn,
  output logic timerOut,
  output logic irq
);

  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
    $error("timer_mode_polarity_control: CNT_W out of range");
  end

  typedef struct packed {
    logic [7:0] ctrl;
    logic modeHi;
    logic [CNT_W-1:0] reload;
    logic [CNT_W-1:0] pwm;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] capture;
    logic started;
    logic pulse;
    logic out;
    logic [timer_ctl_pkg::STATUS_W-1:0] status;
    logic [timer_ctl_pkg::STATUS_W-1:0] mask;
    logic irq;
    logic ack;
    logic [31:0] rdat;
  } state_t;

  state_t q;
  state_t d;

  logic runBit;
  logic polBit;
  timer_ctl_pkg::mode_t mode;
  logic tick;
  logic actEdge;
  logic othEdge;
  logic actLevel;
  logic advance;
  logic reloadEv;
  logic pwmMatch;
  logic captureEv;
  logic wrStrobe;
  logic [timer_ctl_pkg::STATUS_W-1:0] events;

  // ==========================================================
  // helpers
  function automatic logic [31:0] laneMerge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] widen(input logic [CNT_W-1:0] v);
    logic [31:0] r;
    r = '0;
    r[CNT_W-1:0] = v;
    return r;
  endfunction

  function automatic logic hit(input logic [11:0] idx,
                               input logic [timer_ctl_pkg::ADDR_W-1:0] a);
    return a == timer_ctl_pkg::byteAddr(idx);
  endfunction

  assign runBit = q.ctrl[timer_ctl_pkg::RUN_BIT];
  assign polBit = q.ctrl[timer_ctl_pkg::POL_BIT];
  assign mode = timer_ctl_pkg::mode_t'({q.modeHi,
    q.ctrl[timer_ctl_pkg::MODE_LSB +: timer_ctl_pkg::MODE_LO_W]});
  assign wrStrobe = cyc_i && stb_i && we_i && q.ack;

  // ==========================================================
  // submodules
  timer_prescaler #(
    .SHIFT_W(timer_ctl_pkg::PRESCALE_FIELD_W)
  ) u_prescale_field (
    .clk(clk),
    .arst_n(arst_n),
    .run(runBit),
    .shift(q.ctrl[timer_ctl_pkg::PRESCALE_FIELD_LSB +: timer_ctl_pkg::PRESCALE_FIELD_W]),
    .tick(tick)
  );

  timer_input_edge u_edge (
    .clk(clk),
    .arst_n(arst_n),
    .pinIn(timerIn),
    .polarity(polBit),
    .activeEdge(actEdge),
    .otherEdge(othEdge),
    .activeLevel(actLevel)
  );

  // ==========================================================
  // mode dependent count enable
  always_comb begin
    advance = 1'b0;
    captureEv = 1'b0;
    case (mode)
      timer_ctl_pkg::MODE_COUNTER,
      timer_ctl_pkg::MODE_CMP_COUNTER: begin
        advance = actEdge;
      end
      timer_ctl_pkg::MODE_GATED: begin
        advance = tick && actLevel;
      end
      timer_ctl_pkg::MODE_CAP_CMP: begin
        advance = tick && q.started;
        captureEv = actEdge && q.started;
      end
      timer_ctl_pkg::MODE_TRIG_ONESHOT: begin
        advance = tick && q.started;
      end
      timer_ctl_pkg::MODE_CAPTURE,
      timer_ctl_pkg::MODE_CAP_RESTART: begin
        advance = tick;
        captureEv = actEdge;
      end
      default: begin
        advance = tick;
      end
    endcase
    advance = advance && runBit;
    captureEv = captureEv && runBit;
    reloadEv = advance && (q.count == q.reload);
    pwmMatch = advance && (q.count == q.pwm);
    events = '0;
    events[timer_ctl_pkg::ST_RELOAD] = reloadEv;
    events[timer_ctl_pkg::ST_CAPTURE] = captureEv;
    events[timer_ctl_pkg::ST_GATE] = runBit && othEdge
      && (mode == timer_ctl_pkg::MODE_GATED);
  end

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    // counter and capture
    if (!runBit) begin
      d.started = 1'b0;
    end else if (actEdge && (mode == timer_ctl_pkg::MODE_CAP_CMP
        || mode == timer_ctl_pkg::MODE_TRIG_ONESHOT)) begin
      d.started = 1'b1;
    end
    if (captureEv) begin
      d.capture = q.count;
    end
    if (captureEv && mode == timer_ctl_pkg::MODE_CAP_RESTART) begin
      d.count = COUNT_START;
    end else if (reloadEv) begin
      d.count = COUNT_START;
      if (mode == timer_ctl_pkg::MODE_ONESHOT
          || mode == timer_ctl_pkg::MODE_TRIG_ONESHOT) begin
        d.ctrl[timer_ctl_pkg::RUN_BIT] = 1'b0;
      end
    end else if (advance) begin
      d.count = q.count + 1'b1;
    end
    // output pin
    d.pulse = 1'b0;
    if (!runBit) begin
      d.out = polBit;
    end else begin
      case (mode)
        timer_ctl_pkg::MODE_ONESHOT: begin
          if (q.pulse) begin
            d.out = !q.out;
          end else if (reloadEv) begin
            d.out = !q.out;
            d.pulse = 1'b1;
          end
        end
        timer_ctl_pkg::MODE_PWM_ONE,
        timer_ctl_pkg::MODE_PWM_TWO: begin
          if (reloadEv) begin
            d.out = polBit;
          end else if (pwmMatch) begin
            d.out = !polBit;
          end
        end
        default: begin
          if (reloadEv) begin
            d.out = !q.out;
          end
        end
      endcase
    end
    // bus slave
    d.ack = cyc_i && stb_i && !q.ack;
    d.rdat = '0;
    if (cyc_i && stb_i && !we_i && !q.ack) begin
      if (hit(timer_ctl_pkg::IDX_CTRL, adr_i)) begin
        d.rdat[7:0] = q.ctrl;
      end else if (hit(timer_ctl_pkg::IDX_MODE_HI, adr_i)) begin
        d.rdat[0] = q.modeHi;
      end else if (hit(timer_ctl_pkg::IDX_RELOAD, adr_i)) begin
        d.rdat = widen(q.reload);
      end else if (hit(timer_ctl_pkg::IDX_PWM, adr_i)) begin
        d.rdat = widen(q.pwm);
      end else if (hit(timer_ctl_pkg::IDX_COUNT, adr_i)) begin
        d.rdat = widen(q.count);
      end else if (hit(timer_ctl_pkg::IDX_CAPTURE, adr_i)) begin
        d.rdat = widen(q.capture);
      end else if (hit(timer_ctl_pkg::IDX_STATUS, adr_i)) begin
        d.rdat[timer_ctl_pkg::STATUS_W-1:0] = q.status;
      end else if (hit(timer_ctl_pkg::IDX_MASK, adr_i)) begin
        d.rdat[timer_ctl_pkg::STATUS_W-1:0] = q.mask;
      end
    end
    d.status = q.status;
    if (wrStrobe) begin
      if (hit(timer_ctl_pkg::IDX_CTRL, adr_i) && sel_i[0]) begin
        d.ctrl = dat_i[7:0];
      end
      if (hit(timer_ctl_pkg::IDX_MODE_HI, adr_i) && sel_i[0]) begin
        d.modeHi = dat_i[0];
      end
      if (hit(timer_ctl_pkg::IDX_RELOAD, adr_i)) begin
        d.reload = CNT_W'(laneMerge(widen(q.reload), dat_i, sel_i));
      end
      if (hit(timer_ctl_pkg::IDX_PWM, adr_i)) begin
        d.pwm = CNT_W'(laneMerge(widen(q.pwm), dat_i, sel_i));
      end
      if (hit(timer_ctl_pkg::IDX_STATUS, adr_i) && sel_i[0]) begin
        d.status = q.status & ~dat_i[timer_ctl_pkg::STATUS_W-1:0];
      end
      if (hit(timer_ctl_pkg::IDX_MASK, adr_i) && sel_i[0]) begin
        d.mask = dat_i[timer_ctl_pkg::STATUS_W-1:0];
      end
    end
    // set wins over a simultaneous clear
    d.status = d.status | events;
    d.irq = |(d.status & d.mask);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.ctrl <= timer_ctl_pkg::CTRL_RESET;
      q.reload <= RELOAD_RESET;
      q.status <= timer_ctl_pkg::STATUS_RESET;
      q.mask <= timer_ctl_pkg::MASK_RESET;
    end else begin
      q <= d;
    end
  end

  assign dat_o = q.rdat;
  assign ack_o = q.ack;
  assign timerOut = q.out;
  assign irq = q.irq;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_stop_out_pol: assert property (
    !runBit |=> timerOut == $past(polBit))
    else $error("stopped output not at polarity");

  a_oneshot_pulse: assert property (
    runBit && mode == timer_ctl_pkg::MODE_ONESHOT && reloadEv && !q.pulse
    |=> (timerOut != $past(timerOut)) ##1 (timerOut == $past(timerOut, 2)))
    else $error("single-shot pulse not one cycle");

  a_cont_toggle: assert property (
    runBit && mode == timer_ctl_pkg::MODE_CONT && reloadEv
    |=> timerOut != $past(timerOut))
    else $error("continuous output did not toggle");

  a_counter_edge: assert property (
    runBit && mode == timer_ctl_pkg::MODE_COUNTER && actEdge
    && q.count != q.reload |=> q.count == $past(q.count) + 1'b1)
    else $error("counter missed selected edge");

  a_pwm_match: assert property (
    runBit && mode == timer_ctl_pkg::MODE_PWM_ONE && pwmMatch && !reloadEv
    |=> timerOut == !$past(polBit))
    else $error("pwm match level wrong");

  a_capture_latch: assert property (
    runBit && mode == timer_ctl_pkg::MODE_CAPTURE && actEdge
    |=> q.capture == $past(q.count) && q.status[timer_ctl_pkg::ST_CAPTURE])
    else $error("capture not latched");

  a_gated_hold: assert property (
    runBit && mode == timer_ctl_pkg::MODE_GATED && !actLevel
    |=> q.count == $past(q.count))
    else $error("gated counter advanced while gate closed");

  a_capcmp_wait: assert property (
    runBit && mode == timer_ctl_pkg::MODE_CAP_CMP && !q.started
    |=> q.count == $past(q.count) && q.capture == $past(q.capture))
    else $error("capture/compare counted before first edge");

  a_reload_irq: assert property (
    reloadEv && q.mask[timer_ctl_pkg::ST_RELOAD] && !wrStrobe |=> irq)
    else $error("reload event did not raise interrupt");

endmodule

`default_nettype wire

// [timer_pin_model.sv]
// Purpose: model of the external timer input pin
// Assumes: level changes land on a rising clock edge
// Notes: holds each requested level until a new one is asked for

`timescale 1ns/10ps
`default_nettype none

module timer_pin_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wantLevel,
  output logic pinLevel
);
  // ==========================================================
  // pin driver, one register like a real synchronised pin
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinLevel <= 1'b0;
    end else begin
      pinLevel <= wantLevel;
    end
  end
endmodule

`default_nettype wire

// [timer_prescaler.sv]
// Purpose: power-of-two prescaler giving a one-cycle count enable
// Assumes: run low clears the divider so each start divides cleanly
// Notes: tick every 2^shift cycles while running

`timescale 1ns/10ps
`default_nettype none

module timer_prescaler #(
  parameter int SHIFT_W = 3
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic [SHIFT_W-1:0] shift,
  output logic tick
);

  localparam int DIV_W = (1 << SHIFT_W) - 1;

  if (SHIFT_W < 1 || SHIFT_W > 4) begin : g_bad_width
    $error("timer_prescaler: SHIFT_W out of range");
  end

  typedef struct packed {
    logic [DIV_W-1:0] div;
  } pre_state_t;

  pre_state_t q;
  pre_state_t d;
  logic [DIV_W-1:0] lowMask;

  // ==========================================================
  // divider
  always_comb begin
    d = q;
    lowMask = ~({DIV_W{1'b1}} << shift);
    tick = run && ((q.div & lowMask) == lowMask);
    if (!run) begin
      d.div = '0;
    end else begin
      d.div = q.div + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  a_prescale_field_stopped: assert property (@(posedge clk) disable iff (!arst_n)
    !run |=> (q.div == '0) && !(run && shift != '0 && tick))
    else $error("prescaler not cleared while stopped");

endmodule

`default_nettype wire
